// [hdl/flash_host_pkg.sv]
// Package for the flash/static-memory host controller.
// Assumes a 100 MHz clock and an asynchronous external memory bus.
package flash_host_pkg;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          STROBE_NS       = 70;                         // Strobe low time
  localparam int          STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  STROBE_CYC_W    = 4'(STROBE_CYC);
  localparam logic [15:0] RESET_DATA      = 16'h00f0;                  // Software reset command
  localparam logic [15:0] PROTECTED_VAL   = 16'h0001;                  // Protect verify answer
  localparam logic [6:0]  PROT_ID_MASK    = 7'h43;                     // Address bits 6, 1, 0
  localparam logic [6:0]  PROT_ID_PATTERN = 7'h02;                     // Pattern 0,1,0
  localparam int          DQ6_POS         = 6;
  localparam int          ADDR_W          = 21;
  localparam int          DATA_W          = 16;
  localparam logic [2:0]  SYNC_RESET      = 3'b111;
endpackage : flash_host_pkg

// [hdl/flash_host_ctrl.sv]
// Host controller driving a combined flash and static memory package over its pins.
// Assumes the pins are wired directly to the memory; data bus is split in/out/enable.
// Functional notes
// - The host clears the command register with a reset command before a flash write when req_clear is set.
// - The host keeps write strobe high throughout every read cycle.
// - Block erase polling uses an address inside the block; chip erase polling any address.
// - During erase suspend, polling uses an address outside the suspended block.
// - Protect verify presents the block address with ID bits 6,1,0 set to 0,1,0.
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic              clk,                // 100 MHz clock
  input  wire logic              resetn,             // Async reset, active low
  input  wire logic              req_valid,          // Request strobe
  output logic                   req_ready,          // Controller idle
  input  wire logic              req_write,          // 1 write, 0 read
  input  wire logic              req_sram,           // 1 static memory, 0 flash
  input  wire logic              req_clear,          // Prefix a reset command (flash write)
  input  wire logic [ADDR_W-1:0] req_addr,           // Address
  input  wire logic [DATA_W-1:0] req_wdata,          // Write data
  output logic                   rsp_valid,          // Read data valid pulse
  output logic [DATA_W-1:0]      rsp_rdata,          // Read data
  output logic                   rsp_toggled,        // Toggle bit changed since last read
  output logic                   rsp_protected,      // Read equals protect answer
  output logic [ADDR_W-1:0]      mem_addr,           // Address pins
  output logic [DATA_W-1:0]      dq_o,               // Data out
  output logic                   dq_oe,              // Data out enable
  input  wire logic [DATA_W-1:0] dq_i,               // Data in
  output logic                   we_n,               // Write strobe
  output logic                   oe_n,               // Output enable
  output logic                   flash_select_n,     // Flash select
  output logic                   static_mem_select_n,  // Static select low
  output logic                   static_mem_select_hi  // Static select high
);
  typedef enum logic [2:0] {IDLE, CLR_SEL, CLR_WE, SETUP, STROBE, HOLD} state_e;

  state_e            state_q, state_d;
  logic [3:0]        cnt_q;
  logic              clr_q, wr_q, sram_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic              rvalid_q, tog_q, last_dq6_q, seen_q, prot_q;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;
  logic              cnt_done, take, strobe_now, rd_take;

  function automatic logic is_protected(input logic [DATA_W-1:0] v);
    return v == PROTECTED_VAL;
  endfunction : is_protected

  // Handshake and phase decode
  assign req_ready  = (state_q == IDLE);
  assign take       = req_valid && req_ready;
  assign cnt_done   = (cnt_q == STROBE_CYC_W);
  assign strobe_now = (state_q == STROBE) || (state_q == CLR_WE);
  assign rd_take    = (state_q == STROBE) && cnt_done && !wr_q;

  // Pin drive: selects asserted before strobe and released after it
  assign mem_addr             = addr_q;
  assign dq_o                 = clr_q ? RESET_DATA : wdata_q;
  assign dq_oe                = (wr_q || clr_q) && state_q != IDLE;
  assign we_n                 = !((wr_q || state_q == CLR_WE) && strobe_now);
  assign oe_n                 = !(!wr_q && state_q == STROBE && !clr_q);
  assign flash_select_n       = !(state_q != IDLE && !sram_q);
  assign static_mem_select_n  = !(state_q != IDLE && sram_q);
  assign static_mem_select_hi = (state_q != IDLE && sram_q);
  assign rsp_valid            = rvalid_q;
  assign rsp_rdata            = rdata_q;
  assign rsp_toggled          = tog_q;
  assign rsp_protected        = prot_q;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE:    if (take) state_d = (req_clear && !req_sram && req_write) ? CLR_SEL : SETUP;
      CLR_SEL: state_d = CLR_WE;
      CLR_WE:  if (cnt_done) state_d = SETUP;
      SETUP:   state_d = STROBE;
      STROBE:  if (cnt_done) state_d = HOLD;
      HOLD:    state_d = IDLE;
      default: state_d = IDLE;
    endcase
  end

  // State, counter and request capture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= IDLE;
      cnt_q   <= 4'h0;
      clr_q   <= 1'b0;
      wr_q    <= 1'b0;
      sram_q  <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (strobe_now && !cnt_done) ? cnt_q + 4'h1 : 4'h0;
      if (take) begin
        clr_q   <= req_clear && !req_sram && req_write;
        wr_q    <= req_write;
        sram_q  <= req_sram;
        addr_q  <= req_addr;
        wdata_q <= req_wdata;
      end else if (state_q == SETUP) begin  // Reset data held past the strobe rise
        clr_q <= 1'b0;
      end
    end
  end

  // Data pin synchroniser, three stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Read capture at end of strobe, toggle tracking
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      tog_q      <= 1'b0;
      last_dq6_q <= 1'b0;
      seen_q     <= 1'b0;
      prot_q     <= 1'b0;
    end else begin
      rvalid_q <= 1'b0;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= s3_q;
        prot_q   <= is_protected(s3_q);
        if (!sram_q && s2_q == s3_q) begin
          tog_q      <= seen_q && (s3_q[DQ6_POS] != last_dq6_q);
          last_dq6_q <= s3_q[DQ6_POS];
          seen_q     <= 1'b1;
        end
      end
    end
  end

  // Write strobe never low during a read; output enable never low during a write
  property p_read_we_high;
    @(posedge clk) disable iff (!resetn) (!wr_q && state_q != IDLE && !clr_q) |-> we_n;
  endproperty
  a_read_we_high: assert property (p_read_we_high) else $error("we low in read");

  property p_write_oe_high;
    @(posedge clk) disable iff (!resetn) (!we_n) |-> oe_n;
  endproperty
  a_write_oe_high: assert property (p_write_oe_high) else $error("oe low in write");

  property p_sram_sel_before_we;
    @(posedge clk) disable iff (!resetn) $fell(we_n) && sram_q |-> $past(!static_mem_select_n);
  endproperty
  a_sram_sel_before_we: assert property (p_sram_sel_before_we) else $error("sel late");

  property p_sram_desel_after_we;
    @(posedge clk) disable iff (!resetn) $rose(static_mem_select_n) |-> $past(we_n, 1);
  endproperty
  a_sram_desel_after_we: assert property (p_sram_desel_after_we) else $error("desel early");

  property p_clear_first;
    @(posedge clk) disable iff (!resetn) (state_q == CLR_SEL) |=> !we_n && dq_o == RESET_DATA;
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("no reset cmd");

  property p_strobe_len;
    @(posedge clk) disable iff (!resetn) $rose(state_q == STROBE) |-> ##8 state_q == HOLD;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe hung");

  property p_idle_quiet;
    @(posedge clk) disable iff (!resetn) (state_q == IDLE) |-> we_n && oe_n && flash_select_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("strobe active while idle");

  property p_addr_hold;
    @(posedge clk) disable iff (!resetn)
      (state_q != IDLE && $past(state_q) != IDLE) |-> $stable(mem_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");

  property p_data_hold_we;
    @(posedge clk) disable iff (!resetn) $rose(we_n) |-> $stable(dq_o) && dq_oe;
  endproperty
  a_data_hold_we: assert property (p_data_hold_we) else $error("data moved at strobe");

  property p_oe_one_sel;
    @(posedge clk) disable iff (!resetn)
      !oe_n |-> we_n && (flash_select_n != static_mem_select_n);
  endproperty
  a_oe_one_sel: assert property (p_oe_one_sel) else $error("bad read select");

  property p_sram_sel_we_high;
    @(posedge clk) disable iff (!resetn) $fell(static_mem_select_n) |-> we_n;
  endproperty
  a_sram_sel_we_high: assert property (p_sram_sel_we_high) else $error("sel with we");

  property p_clear_flash_only;
    @(posedge clk) disable iff (!resetn)
      (state_q == CLR_SEL) |-> !flash_select_n && static_mem_select_n;
  endproperty
  a_clear_flash_only: assert property (p_clear_flash_only) else $error("clear off flash");

  property p_rsp_pulse;
    @(posedge clk) disable iff (!resetn) rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");
endmodule : flash_host_ctrl

// [tb/mem_model.sv]
// Pin-level model of the combined flash and static memory package.
// Assumes the host pins are wired straight in; clk paces idle bus noise and samples bus clashes.
`timescale 1ns/1ps
module mem_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_READS = 3  // Reads that still see an operation busy
) (
  input  wire logic              clk,     // Bench clock
  input  wire logic [ADDR_W-1:0] addr,    // Address pins
  input  wire logic [DATA_W-1:0] dq_o,    // Host data
  input  wire logic              dq_oe,   // Host drives data
  input  wire logic              we_n,    // Write strobe
  input  wire logic              oe_n,    // Output enable
  input  wire logic              fsel_n,  // Flash select
  input  wire logic              s_n,     // Static select low
  input  wire logic              s_hi,    // Static select high
  output logic [DATA_W-1:0]      dq,      // Data back to host
  output logic                   clash    // Both sides drove the bus
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] junk = 16'h0;
  logic [DATA_W-1:0] rd;
  logic              hit  = 1'b0;
  logic              tog  = 1'b0;  // Power-on read mode, nothing pending
  int                busy = 0;
  logic              pwr_lock = 1'b0;  // First latch edge ignored after low power-up
  initial #1 pwr_lock = (we_n === 1'b0) && (fsel_n === 1'b0) && (oe_n === 1'b0);
  always @(posedge fsel_n) pwr_lock = 1'b0;
  // Drive only on a pure read of a selected memory
  wire drive = !oe_n && we_n && (!fsel_n || (!s_n && s_hi));
  wire prot  = (addr[6:0] & PROT_ID_MASK) == PROT_ID_PATTERN;
  // Read data: flash gives protect answer, else 16'h1234 carrying the toggle bit; static gives cell data
  assign rd = !fsel_n ? (prot ? PROTECTED_VAL : 16'h1234 | (16'(tog) << DQ6_POS))
                      : mem[addr[3:0]];
  assign dq = drive ? rd : junk;
  assign clash = hit;
  // Released bus changes every cycle so stale data never passes
  always @(posedge clk) begin
    junk <= junk + 16'h3c5b;
    if (drive && dq_oe) hit <= 1'b1;
  end
  // Command latch at the end of a write; reset data drops any fragment
  always @(posedge we_n) begin
    if (pwr_lock) pwr_lock = 1'b0;
    else if (!fsel_n) busy = (dq_o == RESET_DATA) ? 0 : BUSY_READS;
    else if (!s_n && s_hi) mem[addr[3:0]] = dq_o;
  end
  // Each busy flash read flips the toggle bit, idle reads leave it
  always @(negedge oe_n) begin
    if (!fsel_n && busy > 0) begin
      tog = ~tog;
      busy--;
    end
  end
endmodule : mem_model

// [tb/flash_host_ctrl_tb.sv]
// Self-checking bench for the flash/static host controller.
// Assumes the memory model answers within the strobe and busies for 3 reads.
`timescale 1ns/1ps
module flash_host_ctrl_tb
  import flash_host_pkg::*;
;
  logic              clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic              req_sram = 1'b0, req_clear = 1'b0, tg, pr, clash;
  logic              req_ready, rsp_valid, rsp_toggled, rsp_protected, dq_oe, we_n, oe_n;
  logic              fsel_n, s_n, s_hi;
  logic [ADDR_W-1:0] req_addr = '0, mem_addr;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, dq_o, dq_i, q;
  int                err_count = 0, checked = 0, cyc = 0;
  flash_host_ctrl i_flash_host_ctrl (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_sram(req_sram), .req_clear(req_clear),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_toggled(rsp_toggled), .rsp_protected(rsp_protected), .mem_addr(mem_addr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .we_n(we_n), .oe_n(oe_n),
    .flash_select_n(fsel_n), .static_mem_select_n(s_n), .static_mem_select_hi(s_hi));
  mem_model i_mem_model (.clk(clk), .addr(mem_addr), .dq_o(dq_o), .dq_oe(dq_oe), .we_n(we_n),
    .oe_n(oe_n), .fsel_n(fsel_n), .s_n(s_n), .s_hi(s_hi), .dq(dq_i), .clash(clash));
  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  // One access: offer until taken, keep any response, return when idle again
  task automatic acc(input logic w, s, c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    {req_valid, req_write, req_sram, req_clear, req_addr, req_wdata} <= {1'b1, w, s, c, a, d};
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 40);
    req_valid <= 1'b0;
    do begin
      @(posedge clk);
      if (rsp_valid === 1'b1) {q, tg, pr} = {rsp_rdata, rsp_toggled, rsp_protected};
    end while (req_ready !== 1'b1 && ++n < 80);
  endtask : acc
  // Static memory written then read back, flash left alone
  task automatic t_sram;
    acc(1'b1, 1'b1, 1'b0, 21'h3, 16'h5a5a);
    acc(1'b1, 1'b1, 1'b0, 21'h4, 16'ha5a5);
    acc(1'b0, 1'b1, 1'b0, 21'h3, 16'h0);
    chk("sram word 3", 16'h5a5a, q);
    acc(1'b0, 1'b1, 1'b0, 21'h4, 16'h0);
    chk("sram word 4", 16'ha5a5, q);
  endtask : t_sram
  // Cleared program command, then polling until the toggle bit settles
  task automatic t_toggle;
    acc(1'b0, 1'b0, 1'b0, 21'h100, 16'h0);
    chk("idle flash read", 16'h1234, q);
    acc(1'b1, 1'b0, 1'b1, 21'h100, 16'h00a0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b0, 1'b0, 21'h100, 16'h0);
      chk("poll data", (i == 1) ? 16'h1234 : 16'h1274, q);
      chk("toggled", {15'h0, i < 3}, {15'h0, tg});
    end
  endtask : t_toggle
  // Protect verify with the ID pattern, then with it broken
  task automatic t_protect;
    acc(1'b0, 1'b0, 1'b0, 21'h010002, 16'h0);
    chk("protect data", PROTECTED_VAL, q);
    chk("protected", 16'h1, {15'h0, pr});
    acc(1'b0, 1'b0, 1'b0, 21'h010042, 16'h0);
    chk("not protected", 16'h0, {15'h0, pr});
  endtask : t_protect
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // Reset, scenarios, bus contention check, verdict
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_sram();
    t_toggle();
    t_protect();
    chk("bus clash", 16'h0, {15'h0, clash});
    report_and_stop();
  end
endmodule : flash_host_ctrl_tb
